// *** core/iosd_defines.vh ***
// constants for the i/o space decoder and scratch registers
// assumes a core that presents i/o or data-space addresses per cycle
`ifndef IOSD_DEFINES_VH
`define IOSD_DEFINES_VH

`define IOSD_IO_SPAN      8'h40
`define IOSD_BIT_SPAN     8'h20
`define IOSD_DATA_OFFSET  8'h20
`define IOSD_EXT_LO       8'h60
`define IOSD_EXT_HI       8'hFF
`define IOSD_SCRATCH0_IO  6'h1E
`define IOSD_SCRATCH1_IO  6'h0A
`define IOSD_SCRATCH2_IO  6'h0B
`define IOSD_SCRATCH3_IO  6'h19
`define IOSD_SCRATCH_RST  8'h00
`define IOSD_OP_NONE      3'h0
`define IOSD_OP_READ      3'h1
`define IOSD_OP_WRITE     3'h2
`define IOSD_OP_BSET      3'h3
`define IOSD_OP_BCLR      3'h4
`define IOSD_OP_BTEST     3'h5

`endif

// *** core/iosd_scratch.v ***
// one 8-bit scratch register with byte write and single-bit update
// assumes strobes come from the decoder on the same clock
`timescale 1ns/100ps
`include "iosd_defines.vh"
module iosd_scratch #(
  parameter WIDTH = 8
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             bit_en,
  input  wire [2:0]       bit_sel,
  input  wire             bit_val,
  output wire [WIDTH-1:0] value
);
  reg  [WIDTH-1:0] value_ff;
  reg  [WIDTH-1:0] nxt_value;

  always @* begin
    nxt_value = value_ff;
    if (wr_en)
      nxt_value = wr_data;
    else if (bit_en)
      nxt_value[bit_sel] = bit_val;
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      value_ff <= `IOSD_SCRATCH_RST;
    else
      value_ff <= nxt_value;
  end

  assign value = value_ff;
endmodule

// *** core/iosd_decoder.v ***
// i/o space decoder with four scratch registers
// assumes the core issues one access per cycle and holds no other bus
`timescale 1ns/100ps
`include "iosd_defines.vh"
// How it works
// - bit set and clear instructions modify bits in low i/o region
// - skip-if-bit tests read one selected bit of low region registers
// - short i/o instructions use addresses 0x00 to 0x3F only
// - data-space access to an i/o register adds 0x20 to its address
// - every i/o register is reachable with data-space load and store
// - extended range 0x60 to 0xFF only via load and store
// - some status flags clear on a written one, zero leaves them
// - bit set and clear touch only the addressed bit
// - four fully read-write 8-bit scratch registers
// - scratch registers sit in low region with bit access
// - scratch registers reset to zero
module iosd_decoder #(
  parameter NREG = 4
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [2:0]  io_op,
  input  wire        io_space,
  input  wire [7:0]  io_addr,
  input  wire [7:0]  io_wdata,
  input  wire [2:0]  io_bit,
  output reg  [7:0]  io_rdata_ff,
  output reg         io_bit_state_ff,
  output reg         io_skip_ff,
  output reg         io_hit_ff,
  output wire        per_io_valid,
  output wire        per_ext_valid,
  output wire [7:0]  per_addr,
  output wire        per_wr,
  output wire        per_rd,
  output wire [7:0]  per_wdata,
  output wire        per_bit_op,
  output wire [2:0]  per_bit,
  output wire        per_bit_val,
  input  wire [7:0]  per_rdata,
  input  wire        per_hit
);
  // normalised i/o index; io_space=1 means short i/o instruction
  reg  [7:0]  idx;
  reg         is_io;
  reg         is_ext;
  wire        is_bitop;
  wire        in_bit;
  wire [5:0]  sc_addr [0:3];
  wire [7:0]  sc_val  [0:NREG-1];
  reg  [NREG-1:0] sc_hit;
  reg  [7:0]  rd_mux;
  reg         hit_any;
  integer     k;

  assign sc_addr[0] = `IOSD_SCRATCH0_IO;
  assign sc_addr[1] = `IOSD_SCRATCH1_IO;
  assign sc_addr[2] = `IOSD_SCRATCH2_IO;
  assign sc_addr[3] = `IOSD_SCRATCH3_IO;

  assign is_bitop = (io_op == `IOSD_OP_BSET) || (io_op == `IOSD_OP_BCLR) ||
                    (io_op == `IOSD_OP_BTEST);

  always @* begin
    idx    = 8'h00;
    is_io  = 1'b0;
    is_ext = 1'b0;
    if (io_space || is_bitop) begin
      idx   = {2'b00, io_addr[5:0]};
      is_io = (io_addr < `IOSD_IO_SPAN);
    end else if (io_addr >= `IOSD_EXT_LO) begin
      idx    = io_addr;
      is_ext = 1'b1;
    end else if (io_addr >= `IOSD_DATA_OFFSET) begin
      idx   = io_addr - `IOSD_DATA_OFFSET;
      is_io = 1'b1;
    end
  end

  // bit ops limited to low region
  assign in_bit = is_io && (idx < `IOSD_BIT_SPAN);

  wire op_ok = (io_op != `IOSD_OP_NONE) && (is_ext || (is_io &&
               (!is_bitop || in_bit)));

  always @* begin
    sc_hit = {NREG{1'b0}};
    for (k = 0; k < NREG; k = k + 1)
      sc_hit[k] = op_ok && is_io && (idx[5:0] == sc_addr[k]);
  end

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gen_sc
      iosd_scratch #(.WIDTH(8)) u_sc (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (sc_hit[g] && (io_op == `IOSD_OP_WRITE)),
        .wr_data (io_wdata),
        .bit_en  (sc_hit[g] && ((io_op == `IOSD_OP_BSET) ||
                                (io_op == `IOSD_OP_BCLR))),
        .bit_sel (io_bit),
        .bit_val (io_op == `IOSD_OP_BSET),
        .value   (sc_val[g])
      );
    end
  endgenerate

  // peripheral valid strobes blocked when nothing valid is addressed or a scratch hits; per_rd/per_wr follow io_op ungated
  assign per_io_valid  = op_ok && is_io && (sc_hit == {NREG{1'b0}});
  assign per_ext_valid = op_ok && is_ext;
  assign per_addr      = idx;
  assign per_rd        = (io_op == `IOSD_OP_READ) ||
                         (io_op == `IOSD_OP_BTEST);
  assign per_wr        = (io_op == `IOSD_OP_WRITE);
  assign per_wdata     = io_wdata;
  // flags see a single-bit op, not a byte write
  assign per_bit_op    = (io_op == `IOSD_OP_BSET) ||
                         (io_op == `IOSD_OP_BCLR);
  assign per_bit       = io_bit;
  assign per_bit_val   = (io_op == `IOSD_OP_BSET);

  always @* begin
    rd_mux  = 8'h00;
    hit_any = 1'b0;
    for (k = 0; k < NREG; k = k + 1)
      if (sc_hit[k]) begin
        rd_mux  = sc_val[k];
        hit_any = 1'b1;
      end
    if (!hit_any && (per_io_valid || per_ext_valid) && per_hit) begin
      rd_mux  = per_rdata;
      hit_any = 1'b1;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      io_rdata_ff     <= 8'h00;
      io_bit_state_ff <= 1'b0;
      io_skip_ff      <= 1'b0;
      io_hit_ff       <= 1'b0;
    end else begin
      io_rdata_ff     <= hit_any ? rd_mux : 8'h00;
      io_hit_ff       <= hit_any;
      io_bit_state_ff <= rd_mux[io_bit];
      io_skip_ff      <= (io_op == `IOSD_OP_BTEST) && hit_any &&
                         rd_mux[io_bit];
    end
  end
endmodule

// *** sim/iosd_chk_checker.sv ***
// port checker for the i/o space decoder
// bound into iosd_decoder, single clock domain
`timescale 1ns/100ps
`include "iosd_defines.vh"
module iosd_chk (
  input wire       clock,
  input wire       rst,
  input wire [2:0] io_op,
  input wire       io_space,
  input wire [7:0] io_addr,
  input wire [7:0] io_wdata,
  input wire [2:0] io_bit,
  input wire [7:0] io_rdata_ff,
  input wire       io_bit_state_ff,
  input wire       io_skip_ff,
  input wire       io_hit_ff,
  input wire       per_ext_valid,
  input wire       per_wr,
  input wire       per_bit_op,
  input wire [2:0] per_bit,
  input wire       per_bit_val
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire rd  = io_op == 3'h1;
  wire wr  = io_op == 3'h2;
  wire bop = io_op == 3'h3 || io_op == 3'h4;
  wire nul = io_rdata_ff == 8'h00 && !io_hit_ff;
  wire s0  = io_space && io_addr == {2'b00, `IOSD_SCRATCH0_IO};
  property p_rng; rd && io_space && io_addr > 8'h3F |=> nul; endproperty
  property p_low; rd && !io_space && io_addr < 8'h20 |=> nul; endproperty
  property p_bit; bop && io_addr > 8'h1F |=> !io_hit_ff; endproperty
  property p_ext; rd && !io_space && io_addr > 8'h5F |-> per_ext_valid;
  endproperty
  property p_sio; (rd || wr) && io_space |-> !per_ext_valid; endproperty
  property p_rw; wr && s0 ##1 rd && s0 |=> io_rdata_ff == $past(io_wdata, 2);
  endproperty
  property p_skp; io_op == 3'h5 && io_addr < 8'h20 |=> io_skip_ff ==
    io_bit_state_ff; endproperty
  property p_idl; io_op == 3'h0 |=> nul; endproperty
  property p_pbo; bop |-> per_bit_op && !per_wr && per_bit == io_bit &&
    per_bit_val == (io_op == 3'h3); endproperty
  a_rng: assert property (p_rng) else $error("short range");
  a_low: assert property (p_low) else $error("low data addr");
  a_bit: assert property (p_bit) else $error("bit op range");
  a_ext: assert property (p_ext) else $error("ext not sent");
  a_sio: assert property (p_sio) else $error("short to ext");
  a_rw: assert property (p_rw) else $error("scratch rw");
  a_skp: assert property (p_skp) else $error("skip bit");
  a_idl: assert property (p_idl) else $error("idle data");
  a_pbo: assert property (p_pbo) else $error("bit op to per");
  c_wr: cover property (wr && s0);
  c_skp: cover property (io_skip_ff);
  c_ext: cover property (per_ext_valid);
endmodule
bind iosd_decoder iosd_chk i_iosd_chk (.*);

// *** sim/iosd_per_mdl.sv ***
// peripheral register file model on the far side
// io index 0x05 and whole extended range decode here
`timescale 1ns/100ps
module iosd_per_mdl (
  input  wire       clock,
  input  wire       rst,
  input  wire       per_io_valid,
  input  wire       per_ext_valid,
  input  wire [7:0] per_addr,
  input  wire       per_wr,
  input  wire [7:0] per_wdata,
  output wire [7:0] per_rdata,
  output wire       per_hit
);
  reg  [7:0] io_ff;
  reg  [7:0] ext_ff;
  wire       sel_io = per_io_valid && per_addr == 8'h05;
  assign per_hit   = sel_io || per_ext_valid;
  assign per_rdata = sel_io ? io_ff : per_ext_valid ? ext_ff : 8'h5A;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      io_ff  <= 8'h00;
      ext_ff <= 8'h00;
    end else if (per_wr && sel_io)
      io_ff  <= per_wdata;
    else if (per_wr && per_ext_valid)
      ext_ff <= per_wdata;
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the i/o space decoder
// core side driven at falling edges, peripheral model on far side
`timescale 1ns/100ps
`include "iosd_defines.vh"
module testbench;
  reg        clock = 0, rst = 1, io_space = 0;
  reg  [2:0] io_op = 0, io_bit = 0;
  reg  [7:0] io_addr = 0, io_wdata = 0;
  wire [7:0] io_rdata_ff, per_addr, per_wdata, per_rdata;
  wire [2:0] per_bit;
  wire       io_bit_state_ff, io_skip_ff, io_hit_ff, per_io_valid;
  wire       per_ext_valid, per_wr, per_rd, per_bit_op, per_bit_val, per_hit;
  integer    err_total = 0, compares = 0, cyc = 0, i;
  reg  [7:0] sa [0:3];
  iosd_decoder i_iosd_decoder (.*);
  iosd_per_mdl i_iosd_per_mdl (.*);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 200) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task acc(input [2:0] op, input sp, input [7:0] ad, wd, input [2:0] b);
    {io_op, io_space, io_addr, io_wdata, io_bit} = {op, sp, ad, wd, b};
    @(negedge clock);
  endtask
  task print_verdict;
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    sa[0] = {2'b00, `IOSD_SCRATCH0_IO};
    sa[1] = {2'b00, `IOSD_SCRATCH1_IO};
    sa[2] = {2'b00, `IOSD_SCRATCH2_IO};
    sa[3] = {2'b00, `IOSD_SCRATCH3_IO};
    repeat (3) @(negedge clock);
    rst = 0;
    for (i = 0; i < 4; i = i + 1) begin
      acc(1, 1, sa[i], 0, 0);
      chk(io_rdata_ff, `IOSD_SCRATCH_RST);
    end
    for (i = 0; i < 4; i = i + 1) begin
      acc(2, 1, sa[i], 8'hC3 ^ i[7:0], 0);
      acc(1, 1, sa[i], 0, 0);
      chk(io_rdata_ff, 8'hC3 ^ i[7:0]);
      acc(1, 0, sa[i] + 8'h20, 0, 0);
      chk({io_rdata_ff[6:0], io_hit_ff}, {7'h43 ^ i[6:0], 1'b1});
    end
    acc(3, 1, sa[0], 0, 2);
    acc(4, 1, sa[0], 0, 7);
    acc(5, 1, sa[0], 0, 2);
    chk({7'h0, io_skip_ff}, 8'h01);
    chk({7'h0, io_bit_state_ff}, 8'h01);
    acc(5, 1, sa[0], 0, 3);
    chk({7'h0, io_skip_ff}, 8'h00);
    acc(1, 1, sa[0], 0, 0);
    chk(io_rdata_ff, 8'h47);
    acc(3, 1, sa[1] + 8'h20, 0, 2);
    chk({7'h0, io_hit_ff}, 8'h00);
    acc(1, 1, sa[1], 0, 0);
    chk(io_rdata_ff, 8'hC2);
    acc(2, 1, 8'h05, 8'h3C, 0);
    acc(1, 0, 8'h25, 0, 0);
    chk(io_rdata_ff, 8'h3C);
    acc(2, 0, 8'h80, 8'h99, 0);
    acc(1, 0, 8'h80, 0, 0);
    chk(io_rdata_ff, 8'h99);
    acc(1, 1, 8'h80, 0, 0);
    chk(io_rdata_ff, 8'h00);
    acc(1, 0, 8'h10, 0, 0);
    chk(io_rdata_ff, 8'h00);
    acc(1, 1, 8'h30, 0, 0);
    chk(io_rdata_ff, 8'h00);
    acc(0, 0, 0, 0, 0);
    print_verdict;
  end
endmodule
